/* verilog/ddc_config.sv */
// down-converter configuration registers, datapath and output fifo
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// output fifo
// ------------------------------------------------------------------
module ddc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic inRdy_q, inRdy_d, outV_q, outV_d;
   logic [WIDTH-1:0] outD_q, outD_d;
   logic push, load;

   assign push = inValid && inRdy_q;
   assign load = (cnt_q != '0) && (!outV_q || outReady);
   assign inReady = inRdy_q;
   assign outValid = outV_q;
   assign outData = outD_q;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      outV_d = outV_q;
      outD_d = outD_q;
      if (outV_q && outReady) begin
         outV_d = 1'b0;
      end
      if (load) begin
         outV_d = 1'b1;
         outD_d = mem[rd_q];
         rd_d = rd_q + 1'b1;
      end
      if (push) begin
         wr_d = wr_q + 1'b1;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
      inRdy_d = cnt_d < (AW+1)'(DEPTH);
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= inData;
      end
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         inRdy_q <= 1'b1;
         outV_q <= 1'b0;
         outD_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         inRdy_q <= inRdy_d;
         outV_q <= outV_d;
         outD_q <= outD_d;
      end
   end
endmodule : ddc_fifo

// ------------------------------------------------------------------
// top: register slave and down-converter datapath
// ------------------------------------------------------------------
module ddc_config (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // axi4-lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [9:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [9:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // converter samples
   input wire logic sampleValid,
   output logic sampleReady,
   input wire logic [13:0] adcA,
   input wire logic [13:0] adcB,
   // output stream
   output logic outValid,
   input wire logic outReady,
   output logic [31:0] outData
);
   logic [7:0] path_q, path_d, mode_q, mode_d, gain_q, gain_d;
   logic [7:0] ordA_q, ordA_d, awIdx_q, awIdx_d, wByte_q, wByte_d;
   logic [31:0] freq_q, freq_d, rdata_q, rdata_d;
   logic awHeld_q, awHeld_d, awOk_q, awOk_d, wHeld_q, wHeld_d;
   logic wEn_q, wEn_d, awRdy_q, awRdy_d, wRdy_q, wRdy_d;
   logic bvalid_q, bvalid_d, arRdy_q, arRdy_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   function automatic logic isMapped(input logic [9:0] a);
      return a[9:2] inside {ddc_pkg::IDX_PATH, ddc_pkg::IDX_MODE,
         ddc_pkg::IDX_GAIN, ddc_pkg::IDX_ORDA, ddc_pkg::IDX_FRQ0,
         ddc_pkg::IDX_FRQ1, ddc_pkg::IDX_FRQ2, ddc_pkg::IDX_FRQ3,
         ddc_pkg::IDX_PHASE};
   endfunction : isMapped

   logic [31:0] accA_q, accA_d, accB_q, accB_d;
   logic [31:0] actA_q, actA_d, actB_q, actB_d;
   logic resA_q, resA_d, resB_q, resB_d, rdyS_q, rdyS_d;
   logic [1:0] qcA_q, qcA_d, qcB_q, qcB_d, stCnt_q, stCnt_d;
   logic [4:0] cnt_q, cnt_d;
   logic signed [20:0] sum_q [4], sum_d [4];
   logic [15:0] heldI_q, heldI_d;
   logic [31:0] stW0_q, stW0_d, stW1_q, stW1_d;

   assign awready = awRdy_q;
   assign wready = wRdy_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arRdy_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign sampleReady = rdyS_q;

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   always_comb begin
      path_d = path_q;
      mode_d = mode_q;
      gain_d = gain_q;
      ordA_d = ordA_q;
      freq_d = freq_q;
      awHeld_d = awHeld_q;
      awIdx_d = awIdx_q;
      awOk_d = awOk_q;
      wHeld_d = wHeld_q;
      wByte_d = wByte_q;
      wEn_d = wEn_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (awvalid && awRdy_q) begin
         awHeld_d = 1'b1;
         awIdx_d = awaddr[9:2];
         awOk_d = isMapped(awaddr);
      end
      if (wvalid && wRdy_q) begin
         wHeld_d = 1'b1;
         wByte_d = wdata[7:0];
         wEn_d = wstrb[0];
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (awHeld_q && wHeld_q && !bvalid_q) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = awOk_q ? ddc_pkg::RESP_OKAY : ddc_pkg::RESP_SLVERR;
         if (wEn_q) begin
            case (awIdx_q)
               ddc_pkg::IDX_PATH: path_d = wByte_q;
               ddc_pkg::IDX_MODE: mode_d = wByte_q;
               ddc_pkg::IDX_GAIN: gain_d = wByte_q;
               ddc_pkg::IDX_ORDA: ordA_d = wByte_q;
               ddc_pkg::IDX_FRQ0: freq_d[7:0] = wByte_q;
               ddc_pkg::IDX_FRQ1: freq_d[15:8] = wByte_q;
               ddc_pkg::IDX_FRQ2: freq_d[23:16] = wByte_q;
               ddc_pkg::IDX_FRQ3: freq_d[31:24] = wByte_q;
               default: ;
            endcase
         end
      end
      if (mode_d[ddc_pkg::MODE_REAL]) begin
         freq_d = '0;
      end
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (arvalid && arRdy_q) begin
         rvalid_d = 1'b1;
         rresp_d = isMapped(araddr) ? ddc_pkg::RESP_OKAY
                                    : ddc_pkg::RESP_SLVERR;
         case (araddr[9:2])
            ddc_pkg::IDX_PATH: rdata_d = {24'h0, path_q};
            ddc_pkg::IDX_MODE: rdata_d = {24'h0, mode_q};
            ddc_pkg::IDX_GAIN: rdata_d = {24'h0, gain_q};
            ddc_pkg::IDX_ORDA: rdata_d = {24'h0, ordA_q};
            ddc_pkg::IDX_FRQ0: rdata_d = {24'h0, freq_q[7:0]};
            ddc_pkg::IDX_FRQ1: rdata_d = {24'h0, freq_q[15:8]};
            ddc_pkg::IDX_FRQ2: rdata_d = {24'h0, freq_q[23:16]};
            ddc_pkg::IDX_FRQ3: rdata_d = {24'h0, freq_q[31:24]};
            ddc_pkg::IDX_PHASE: rdata_d = accA_q;
            default: rdata_d = '0;
         endcase
      end
      awRdy_d = !awHeld_d;
      wRdy_d = !wHeld_d;
      arRdy_d = !rvalid_d;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         path_q <= ddc_pkg::REG_RESET;
         mode_q <= ddc_pkg::REG_RESET;
         gain_q <= ddc_pkg::REG_RESET;
         ordA_q <= ddc_pkg::REG_RESET;
         freq_q <= '0;
         awHeld_q <= 1'b0;
         awIdx_q <= '0;
         awOk_q <= 1'b0;
         wHeld_q <= 1'b0;
         wByte_q <= '0;
         wEn_q <= 1'b0;
         awRdy_q <= 1'b1;
         wRdy_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= ddc_pkg::RESP_OKAY;
         arRdy_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= ddc_pkg::RESP_OKAY;
      end else begin
         path_q <= path_d;
         mode_q <= mode_d;
         gain_q <= gain_d;
         ordA_q <= ordA_d;
         freq_q <= freq_d;
         awHeld_q <= awHeld_d;
         awIdx_q <= awIdx_d;
         awOk_q <= awOk_d;
         wHeld_q <= wHeld_d;
         wByte_q <= wByte_d;
         wEn_q <= wEn_d;
         awRdy_q <= awRdy_d;
         wRdy_q <= wRdy_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arRdy_q <= arRdy_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   // square-wave oscillator: quadrant sign only, keeps the mixer free
   // of multipliers at the cost of harmonic images
   function automatic logic [31:0] mixIQ(input logic signed [15:0] x,
                                         input logic [1:0] ph,
                                         input logic quarter);
      logic signed [15:0] n;
      n = -x;
      if (quarter) begin
         case (ph)
            2'h0: return {x, 16'h0};
            2'h1: return {16'h0, n};
            2'h2: return {n, 16'h0};
            default: return {16'h0, x};
         endcase
      end
      return {(ph == 2'h0 || ph == 2'h3) ? x : n, ph[1] ? x : n};
   endfunction : mixIQ

   // 3 dB approximated by 1.375 to stay add-only
   function automatic logic signed [15:0] mixGain(
         input logic signed [15:0] x, input logic [1:0] code);
      case (code)
         ddc_pkg::GAIN_3DB: return x + (x >>> 2) + (x >>> 3);
         ddc_pkg::GAIN_6DB: return x <<< 1;
         default: return x;
      endcase
   endfunction : mixGain

   logic signed [15:0] sa, sb, inA, inB, smp [4], dump [4];
   logic signed [16:0] sumAB;
   logic [1:0] route, phA, phB;
   logic [2:0] decCode;
   logic [4:0] decLast;
   logic [31:0] mA, mB;
   logic [15:0] iNow, aFirst, aSecond;
   logic realMode, ddcOn, accept, fifoReady, push, swapA, qdelA;
   logic signed [20:0] sum [4];

   assign sa = 16'(signed'(adcA));
   assign sb = 16'(signed'(adcB));
   assign sumAB = 17'(sa) + 17'(sb);
   assign route = mode_q[ddc_pkg::MODE_ROUTE] ?
                  path_q[ddc_pkg::PATH_SEL +: 2] : 2'h0;
   always_comb begin
      case (route)
         ddc_pkg::ROUTE_A: begin inA = sa; inB = sa; end
         ddc_pkg::ROUTE_B: begin inA = sb; inB = sb; end
         ddc_pkg::ROUTE_AVG: begin
            inA = sumAB[16:1];
            inB = sumAB[16:1];
         end
         default: begin inA = sa; inB = sb; end
      endcase
   end

   assign realMode = mode_q[ddc_pkg::MODE_REAL];
   assign decCode = mode_q[ddc_pkg::MODE_DEC +: 3] > ddc_pkg::DEC_MAX ?
                    3'h0 : mode_q[ddc_pkg::MODE_DEC +: 3];
   assign decLast = 5'((6'h1 << decCode) - 6'h1);
   assign ddcOn = path_q[ddc_pkg::PATH_DIG]
                  && path_q[ddc_pkg::PATH_DEC];
   assign accept = sampleValid && rdyS_q;
   assign push = (stCnt_q != 2'h0) && fifoReady;
   assign swapA = ordA_q[ddc_pkg::ORD_SWAP];
   assign qdelA = ordA_q[ddc_pkg::ORD_QDEL];
   assign phA = gain_q[ddc_pkg::QMIX_A] ?
                qcA_q ^ {ordA_q[ddc_pkg::ORD_QPH], 1'b0} :
                accA_q[31:30] ^ {mode_q[ddc_pkg::MODE_PHINV], 1'b0};
   assign phB = gain_q[ddc_pkg::QMIX_B] ? qcB_q :
                accB_q[31:30] ^ {mode_q[ddc_pkg::MODE_PHINV], 1'b0};
   assign mA = mixIQ(inA, phA, gain_q[ddc_pkg::QMIX_A]);
   assign mB = mixIQ(inB, phB, gain_q[ddc_pkg::QMIX_B]);

   always_comb begin
      if (realMode) begin
         smp[0] = inA;
         smp[1] = 16'h0;
         smp[2] = inB;
         smp[3] = 16'h0;
      end else begin
         smp[0] = mixGain(mA[31:16], gain_q[ddc_pkg::GAIN_A +: 2]);
         smp[1] = mixGain(mA[15:0], gain_q[ddc_pkg::GAIN_A +: 2]);
         smp[2] = mixGain(mB[31:16], gain_q[ddc_pkg::GAIN_B +: 2]);
         smp[3] = mixGain(mB[15:0], gain_q[ddc_pkg::GAIN_B +: 2]);
      end
      for (int i = 0; i < 4; i++) begin
         sum[i] = sum_q[i] + 21'(smp[i]);
         dump[i] = 16'(sum[i] >>> decCode);
      end
   end

   assign iNow = qdelA ? heldI_q : dump[0];
   assign aFirst = swapA ? dump[1] : iNow;
   assign aSecond = swapA ? iNow : dump[1];

   always_comb begin
      // phase reset takes the word live at the toggle
      accA_d = accA_q + actA_q;
      actA_d = actA_q;
      accB_d = accB_q + actB_q;
      actB_d = actB_q;
      if (gain_q[ddc_pkg::RES_A] != resA_q) begin
         accA_d = '0;
         actA_d = freq_q;
      end
      if (gain_q[ddc_pkg::RES_B] != resB_q) begin
         accB_d = '0;
         actB_d = freq_q;
      end
      resA_d = gain_q[ddc_pkg::RES_A];
      resB_d = gain_q[ddc_pkg::RES_B];
      qcA_d = qcA_q + 2'h1;
      qcB_d = qcB_q + 2'h1;
      cnt_d = cnt_q;
      sum_d = sum_q;
      heldI_d = heldI_q;
      stW0_d = stW0_q;
      stW1_d = stW1_q;
      stCnt_d = stCnt_q;
      if (push) begin
         stW0_d = stW1_q;
         stCnt_d = stCnt_q - 2'h1;
      end
      if (accept && !ddcOn) begin
         stW0_d = {sb, sa};
         stCnt_d = 2'h1;
      end else if (accept && cnt_q != decLast) begin
         cnt_d = cnt_q + 5'h1;
         sum_d = sum;
      end else if (accept) begin
         cnt_d = '0;
         for (int i = 0; i < 4; i++) sum_d[i] = '0;
         heldI_d = dump[0];
         if (realMode) begin
            stW0_d = {dump[2], dump[0]};
            stCnt_d = 2'h1;
         end else begin
            stW0_d = {dump[2], aFirst};
            stW1_d = {dump[3], aSecond};
            stCnt_d = 2'h2;
         end
      end
      rdyS_d = stCnt_d == 2'h0;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         accA_q <= '0;
         accB_q <= '0;
         actA_q <= '0;
         actB_q <= '0;
         resA_q <= 1'b0;
         resB_q <= 1'b0;
         qcA_q <= '0;
         qcB_q <= '0;
         cnt_q <= '0;
         for (int i = 0; i < 4; i++) sum_q[i] <= '0;
         heldI_q <= '0;
         stW0_q <= '0;
         stW1_q <= '0;
         stCnt_q <= '0;
         rdyS_q <= 1'b0;
      end else begin
         accA_q <= accA_d;
         accB_q <= accB_d;
         actA_q <= actA_d;
         actB_q <= actB_d;
         resA_q <= resA_d;
         resB_q <= resB_d;
         qcA_q <= qcA_d;
         qcB_q <= qcB_d;
         cnt_q <= cnt_d;
         sum_q <= sum_d;
         heldI_q <= heldI_d;
         stW0_q <= stW0_d;
         stW1_q <= stW1_d;
         stCnt_q <= stCnt_d;
         rdyS_q <= rdyS_d;
      end
   end

   ddc_fifo #(.WIDTH(ddc_pkg::WORD_W), .DEPTH(ddc_pkg::FIFO_DEPTH)) fifo (
      .clock(clock),
      .rstn(rstn),
      .inValid(stCnt_q != 2'h0),
      .inReady(fifoReady),
      .inData(stW0_q),
      .outValid(outValid),
      .outReady(outReady),
      .outData(outData)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence ddcDump;
      accept && ddcOn && cnt_q == decLast;
   endsequence
   sequence realDump;
      ddcDump ##0 realMode;
   endsequence

   dump_fill_a: assert property (ddcDump |=> stCnt_q != 2'h0)
      else $error("decimated output not staged");
   real_single_a: assert property (realDump |=> stCnt_q == 2'h1)
      else $error("real mode must stage one word");
   swap_order_a: assert property (ddcDump ##0 (!realMode && swapA)
      |=> stCnt_q == 2'h2 && stW0_q[15:0] == $past(dump[1]))
      else $error("swapped pair must start with Q");
   qdel_pair_a: assert property (ddcDump ##0 (!realMode && qdelA
      && !swapA) |=> stW0_q[15:0] == $past(heldI_q))
      else $error("delayed Q must pair with held I");
   phase_step_a: assert property (resA_q == gain_q[ddc_pkg::RES_A]
      |=> accA_q == $past(accA_q) + $past(actA_q))
      else $error("accumulator step wrong");
   mix_reset_a: assert property ($changed(gain_q[ddc_pkg::RES_A])
      |=> accA_q == '0 && actA_q == $past(freq_q))
      else $error("phase reset toggle ignored");
   freq_zero_a: assert property (realMode |-> freq_q == '0)
      else $error("frequency word not zero in real mode");
   bypass_word_a: assert property (accept && !ddcOn
      |=> stCnt_q == 2'h1 && stW0_q == $past({sb, sa}))
      else $error("bypass word wrong");
   route_off_a: assert property (!mode_q[ddc_pkg::MODE_ROUTE]
      |-> inA == sa && inB == sb)
      else $error("route applied while disabled");
endmodule : ddc_config
`default_nettype wire

/* verilog/ddc_pkg.sv */
// shared constants of the down-converter configuration block
`default_nettype none
package ddc_pkg;
   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_PATH = 8'h24;
   localparam logic [7:0] IDX_MODE = 8'h25;
   localparam logic [7:0] IDX_GAIN = 8'h26;
   localparam logic [7:0] IDX_ORDA = 8'h27;
   localparam logic [7:0] IDX_FRQ0 = 8'h2a;
   localparam logic [7:0] IDX_FRQ1 = 8'h2b;
   localparam logic [7:0] IDX_FRQ2 = 8'h2c;
   localparam logic [7:0] IDX_FRQ3 = 8'h2d;
   localparam logic [7:0] IDX_PHASE = 8'h30;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int PATH_SEL = 3;
   localparam int PATH_DIG = 2;
   localparam int PATH_DEC = 1;
   localparam int MODE_ROUTE = 7;
   localparam int MODE_DEC = 4;
   localparam int MODE_REAL = 3;
   localparam int MODE_PHINV = 0;
   localparam int GAIN_A = 6;
   localparam int RES_A = 5;
   localparam int QMIX_A = 4;
   localparam int GAIN_B = 2;
   localparam int RES_B = 1;
   localparam int QMIX_B = 0;
   localparam int ORD_SWAP = 4;
   localparam int ORD_QDEL = 3;
   localparam int ORD_QPH = 2;
   // ----------------------------------------------------------------
   // codes and sizes
   // ----------------------------------------------------------------
   localparam logic [2:0] DEC_MAX = 3'h5;
   localparam logic [1:0] ROUTE_A = 2'h1;
   localparam logic [1:0] ROUTE_B = 2'h2;
   localparam logic [1:0] ROUTE_AVG = 2'h3;
   localparam logic [1:0] GAIN_3DB = 2'h1;
   localparam logic [1:0] GAIN_6DB = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int FIFO_DEPTH = 32;
   localparam int WORD_W = 32;
endpackage : ddc_pkg
`default_nettype wire

/* tb/ddc_sink.sv */
// stream receiver model: stalls on command, otherwise accepts at random
`timescale 1ns/1ps
`default_nettype none
module ddc_sink (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // control and stream
   input wire logic stall,
   output logic outReady
);
   logic [7:0] lfsrQ;
   logic [7:0] lfsrD;
   logic readyD;
   always_comb begin
      lfsrD = {lfsrQ[6:0], lfsrQ[7] ^ lfsrQ[5] ^ lfsrQ[4] ^ lfsrQ[3]};
      // slow receiver: about one cycle in four refused
      readyD = !stall && (lfsrQ[0] || lfsrQ[1]);
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         lfsrQ <= 8'h5a;
         outReady <= 1'b0;
      end else begin
         lfsrQ <= lfsrD;
         outReady <= readyD;
      end
   end
endmodule : ddc_sink
`default_nettype wire

/* tb/ddc_config_bench.sv */
// self-checking bench for the down-converter configuration block
`timescale 1ns/1ps
`default_nettype none
module ddc_config_bench;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sampleValid = 1'b0, stall = 1'b0;
   logic [9:0] awaddr = 10'h0, araddr = 10'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [13:0] adcA = 14'h0, adcB = 14'h0;
   logic awready, wready, bvalid, arready, rvalid, sampleReady;
   logic outValid, outReady;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, outData, seed = 32'h000121a2;
   logic [33:0] axQ[$];
   logic [31:0] exQ[$];
   int err_total = 0, compares = 0, cyc = 0;
   always #2 clock = ~clock;
   ddc_config u_dut (.clock(clock), .rstn(rstn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .sampleValid(sampleValid), .sampleReady(sampleReady), .adcA(adcA),
      .adcB(adcB), .outValid(outValid), .outReady(outReady),
      .outData(outData));
   ddc_sink u_sink (.clock(clock), .rstn(rstn), .stall(stall),
      .outReady(outReady));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [15:0] sx(input logic [13:0] v);
      return {{2{v[13]}}, v};
   endfunction : sx
   task automatic chk(input string nm, input logic [33:0] e, logic [33:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] i, input logic [7:0] d,
                     input logic [1:0] er);
      logic a;
      logic w;
      a = 1'b1;
      w = 1'b1;
      axQ.push_back({er, 32'h0});
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (a && awready === 1'b1) begin
            awvalid <= 1'b0;
            a = 1'b0;
         end
         if (w && wready === 1'b1) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end while (a || w);
      while (bvalid !== 1'b1) @(posedge clock);
      bready <= 1'b0;
      // one edge with bready low before the next write may raise it
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] i, input logic [31:0] e,
                     input logic [1:0] er);
      axQ.push_back({er, e});
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge clock);
   endtask : rd
   task automatic snd(input logic [13:0] a, input logic [13:0] b);
      adcA <= a;
      adcB <= b;
      sampleValid <= 1'b1;
      do @(posedge clock); while (sampleReady !== 1'b1);
      sampleValid <= 1'b0;
      @(posedge clock);
   endtask : snd
   task automatic drain();
      while (exQ.size() != 0) @(posedge clock);
   endtask : drain
   // ---------------------------------------------------------------
   // result watcher and hang limit
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      cyc++;
      if (rstn && bvalid && bready) chk("bresp", axQ.pop_front(), {bresp, 32'h0});
      if (rstn && rvalid && rready) chk("rdata", axQ.pop_front(), {rresp, rdata});
      if (rstn && outValid && outReady)
         chk("outData", {2'h0, exQ.pop_front()}, {2'h0, outData});
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] rl[8];
      logic [31:0] r;
      logic [13:0] a, b;
      logic [15:0] s, ia, ib;
      rl = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h2a, 8'h2b, 8'h2c, 8'h2d};
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 8; i++) rd(rl[i], 32'h0, ddc_pkg::RESP_OKAY);
      rd(8'h28, 32'h0, ddc_pkg::RESP_SLVERR);
      wr(8'h28, 8'h5a, ddc_pkg::RESP_SLVERR);
      wr(ddc_pkg::IDX_MODE, 8'hd1, 2'h0);
      rd(ddc_pkg::IDX_MODE, 32'hd1, 2'h0);
      wr(ddc_pkg::IDX_GAIN, 8'hb9, 2'h0);
      rd(ddc_pkg::IDX_GAIN, 32'hb9, 2'h0);
      wr(ddc_pkg::IDX_ORDA, 8'h1c, 2'h0);
      rd(ddc_pkg::IDX_ORDA, 32'h1c, 2'h0);
      r = xs();
      for (int i = 0; i < 4; i++) wr(rl[4+i], r[8*i+:8], 2'h0);
      for (int i = 0; i < 4; i++) rd(rl[4+i], {24'h0, r[8*i+:8]}, 2'h0);
      wr(ddc_pkg::IDX_ORDA, 8'h00, 2'h0);
      wr(ddc_pkg::IDX_GAIN, 8'h00, 2'h0);
      wr(ddc_pkg::IDX_MODE, 8'h08, 2'h0);
      for (int i = 0; i < 4; i++) rd(rl[4+i], 32'h0, 2'h0);
      $display("done: registers");
      // fill the fifo against a stalled receiver, then drain it
      wr(ddc_pkg::IDX_MODE, 8'h00, 2'h0);
      stall <= 1'b1;
      fork
         for (int i = 0; i < 40; i++) begin
            r = xs();
            exQ.push_back({sx(r[29:16]), sx(r[13:0])});
            snd(r[13:0], r[29:16]);
         end
         begin
            repeat (300) @(posedge clock);
            chk("sampleReady", 34'h0, {33'h0, sampleReady});
            stall <= 1'b0;
         end
      join
      drain();
      $display("done: bypass fill");
      // real decimation, codes 0 to 5, identical samples keep it exact
      wr(ddc_pkg::IDX_PATH, 8'h06, 2'h0);
      for (int d = 0; d < 6; d++) begin
         wr(ddc_pkg::IDX_MODE, {1'b0, d[2:0], 4'h8}, 2'h0);
         r = xs();
         exQ.push_back({sx(r[29:16]), sx(r[13:0])});
         repeat (1 << d) snd(r[13:0], r[29:16]);
         drain();
      end
      $display("done: decimation");
      // route codes; 4 is route with enable clear, 5 filters off
      for (int t = 0; t < 6; t++) begin
         r = xs();
         a = {r[13:1], 1'b0};
         b = {r[29:17], 1'b0};
         s = sx(a) + sx(b);
         wr(ddc_pkg::IDX_PATH, (t == 5) ? 8'h04 : {2'h0, t == 3,
            t[1:0] | (t == 4), 3'h6}, 2'h0);
         wr(ddc_pkg::IDX_MODE, (t < 4) ? 8'h98 : 8'h18, 2'h0);
         case (t)
            1: exQ.push_back({sx(a), sx(a)});
            2: exQ.push_back({sx(b), sx(b)});
            3: exQ.push_back({2{s[15], s[15:1]}});
            default: exQ.push_back({sx(b), sx(a)});
         endcase
         if (t == 5) exQ.push_back({sx(b), sx(a)});
         repeat (2) snd(a, b);
         drain();
      end
      $display("done: routing");
      // complex mixing at zero frequency: I = 2x, Q = -2x after gain, I = -2x, Q = 2x on the phase-inverted third pass
      for (int i = 0; i < 4; i++) wr(rl[4+i], 8'h00, 2'h0);
      wr(ddc_pkg::IDX_GAIN, 8'ha8, 2'h0);
      wr(ddc_pkg::IDX_PATH, 8'h06, 2'h0);
      wr(ddc_pkg::IDX_MODE, 8'h00, 2'h0);
      rd(ddc_pkg::IDX_PHASE, 32'h0, 2'h0);
      for (int t = 0; t < 3; t++) begin
         r = xs();
         a = r[13:0];
         b = r[29:16];
         ia = sx(a) << 1;
         ib = sx(b) << 1;
         wr(ddc_pkg::IDX_ORDA, {3'h0, t == 0, t == 1, 3'h0}, 2'h0);
         if (t == 2) wr(ddc_pkg::IDX_MODE, 8'h01, 2'h0);
         case (t)
            0: exQ.push_back({ib, -ia});
            1: exQ.push_back({ib, s});
            default: exQ.push_back({-ib, -ia});
         endcase
         case (t)
            0: exQ.push_back({-ib, ia});
            1: exQ.push_back({-ib, -ia});
            default: exQ.push_back({ib, ia});
         endcase
         // held I for the delayed-Q pairing of the next pass
         s = ia;
         snd(a, b);
         drain();
      end
      $display("done: complex");
      repeat (20) @(posedge clock);
      chk("pending", 34'h0, {2'h0, exQ.size()});
      summarize();
   end
endmodule : ddc_config_bench
`default_nettype wire
